// file: src/unb_uart.sv
`timescale 1ns/10ps
module unb_uart
  import unb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        timer2_ext_input,
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin
);

  function automatic logic unb_maj3(input logic [2:0] s);
    unb_maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : unb_maj3

  function automatic logic unb_mapped(input logic [7:0] a);
    unb_mapped = (a == UNB_OFS_CTRL) || (a == UNB_OFS_STAT) ||
                 (a == UNB_OFS_BUF) || (a == UNB_OFS_T1RLD) ||
                 (a == UNB_OFS_T2RLD);
  endfunction : unb_mapped

  // Bit-clock source for one direction
  function automatic logic unb_tick(input logic var_mode, input logic t2sel,
                                    input logic fix, input logic t1p,
                                    input logic t2p);
    unb_tick = !var_mode ? fix : (t2sel ? t2p : t1p);
  endfunction : unb_tick

  logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r, rd_mux;
  logic [7:0]  awaddr_r, araddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_go, buf_wr, stat_wr;
  logic [7:0]  ctrl_r, t1_reload_r;
  logic [15:0] t2_reload_r;
  logic [3:0]  mcyc_r;
  logic        m1s3_r;
  logic [1:0]  osc_div_r;
  logic [7:0]  t1_cnt_r;
  logic        t1_ovf_r, t1_half_r;
  logic [15:0] t2_cnt_r;
  logic        t2_ovf_r, t2_ext_prev_r, t2_inc;
  logic        fix_tick, t1_pulse, tx_tick, rx_tick, tx_bclk;
  logic [3:0]  tx_div_r, tx_idx_r;
  logic [8:0]  tx_shift_r;
  logic [7:0]  tx_data_r;
  logic        tx_busy_r, tx_pend_r, tx_done_ev_r, serial_tx_pin_r;
  unb_rx_st_t  rx_st_r;
  logic [3:0]  rx_cnt_r, rx_idx_r;
  logic [2:0]  rx_smp_r;
  logic [7:0]  rx_shift_r, rx_buf_r;
  logic        rx_d_r, rx_prev_r, rx_ok_r, rx_ovr_r;
  logic        rx_done_ev_r, rx_err_ev_r, rx_maj, rx_hit, rx_eval;
  logic        rx_ninth_eval;
  logic        tx_done_pend_r, rx_done_pend_r, err_pend_r;
  logic        tx_done_flag_r, rx_done_flag_r, serial_error_flag_r;
  logic        rx_ninth_bit_r;

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign serial_tx_pin = serial_tx_pin_r;

  // Write channel: address and data held until both present
  assign wr_go   = !awready_r && !wready_r && !bvalid_r;
  assign buf_wr  = wr_go && awaddr_r == UNB_OFS_BUF && wstrb_r[0];
  assign stat_wr = wr_go && awaddr_r == UNB_OFS_STAT && wstrb_r[0];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= UNB_RESP_OKAY;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= unb_mapped(awaddr_r) ? UNB_RESP_OKAY : UNB_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_r      <= UNB_CTRL_RST;
      t1_reload_r <= UNB_T1_RST;
      t2_reload_r <= UNB_T2_RST;
    end else if (wr_go) begin
      if (awaddr_r == UNB_OFS_CTRL && wstrb_r[0])
        ctrl_r <= wdata_r[7:0];
      if (awaddr_r == UNB_OFS_T1RLD && wstrb_r[0])
        t1_reload_r <= wdata_r[7:0];
      if (awaddr_r == UNB_OFS_T2RLD && wstrb_r[0])
        t2_reload_r[7:0] <= wdata_r[7:0];
      if (awaddr_r == UNB_OFS_T2RLD && wstrb_r[1])
        t2_reload_r[15:8] <= wdata_r[15:8];
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (araddr_r)
      UNB_OFS_CTRL:  rd_mux[7:0] = ctrl_r;
      UNB_OFS_STAT: begin
        rd_mux[UNB_STAT_TXD]  = tx_done_flag_r;
        rd_mux[UNB_STAT_RXD]  = rx_done_flag_r;
        rd_mux[UNB_STAT_ERR]  = serial_error_flag_r;
        rd_mux[UNB_STAT_RB8]  = rx_ninth_bit_r;
        rd_mux[UNB_STAT_BUSY] = tx_busy_r;
      end
      UNB_OFS_BUF:   rd_mux[7:0]  = rx_buf_r;
      UNB_OFS_T1RLD: rd_mux[7:0]  = t1_reload_r;
      UNB_OFS_T2RLD: rd_mux[15:0] = t2_reload_r;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Read: address taken, answer one cycle later
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      arready_r <= 1'b1;
      araddr_r  <= 8'h00;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= UNB_RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      araddr_r  <= {s_axi_araddr[7:2], 2'b00};
      arready_r <= 1'b0;
    end else if (!arready_r && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= unb_mapped(araddr_r) ? UNB_RESP_OKAY : UNB_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // Machine-cycle timing and oscillator dividers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mcyc_r    <= 4'h0;
      m1s3_r    <= 1'b0;
      osc_div_r <= 2'h0;
    end else begin
      mcyc_r    <= (mcyc_r == UNB_MCYC_LAST) ? 4'h0 : mcyc_r + 4'h1;
      m1s3_r    <= (mcyc_r == UNB_M1S3_PHASE);
      osc_div_r <= osc_div_r + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      t1_cnt_r  <= 8'h00;
      t1_ovf_r  <= 1'b0;
      t1_half_r <= 1'b0;
    end else begin
      t1_ovf_r <= 1'b0;
      if (mcyc_r == UNB_MCYC_LAST) begin // [RULE20]
        if (t1_cnt_r == 8'hFF) begin
          t1_cnt_r <= t1_reload_r;
          t1_ovf_r <= 1'b1;
        end else begin
          t1_cnt_r <= t1_cnt_r + 8'h01;
        end
      end
      if (t1_ovf_r)
        t1_half_r <= !t1_half_r;
    end
  end

  assign t2_inc = ctrl_r[UNB_CTRL_T2EXT] ?
                  (t2_ext_prev_r && !timer2_ext_input) : osc_div_r[0];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      t2_cnt_r      <= 16'h0000;
      t2_ovf_r      <= 1'b0;
      t2_ext_prev_r <= 1'b0;
    end else begin
      t2_ext_prev_r <= timer2_ext_input;
      t2_ovf_r      <= 1'b0;
      if (t2_inc) begin // [RULE22]
        if (t2_cnt_r == 16'hFFFF) begin
          t2_cnt_r <= t2_reload_r;
          t2_ovf_r <= 1'b1;
        end else begin
          t2_cnt_r <= t2_cnt_r + 16'h0001;
        end
      end
    end
  end

  // Fixed rate: osc/2 doubled, osc/4 otherwise; timer 1 halved unless doubled
  assign fix_tick = ctrl_r[UNB_CTRL_DBL] ? osc_div_r[0] : &osc_div_r; // [RULE3]
  assign t1_pulse = t1_ovf_r && (ctrl_r[UNB_CTRL_DBL] || t1_half_r); // [RULE19]
  // Timer 2 path ignores the doubler
  assign tx_tick = unb_tick(ctrl_r[UNB_CTRL_VAR], ctrl_r[UNB_CTRL_TXT2],
                            fix_tick, t1_pulse, t2_ovf_r); // [RULE18] [RULE21]
  assign rx_tick = unb_tick(ctrl_r[UNB_CTRL_VAR], ctrl_r[UNB_CTRL_RXT2],
                            fix_tick, t1_pulse, t2_ovf_r); // [RULE17]
  assign tx_bclk = tx_tick && tx_div_r == UNB_CNT_LAST;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      tx_div_r <= 4'h0;
    else if (tx_tick)
      tx_div_r <= tx_div_r + 4'h1; // [RULE2] [RULE3]
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      serial_tx_pin_r <= 1'b1;
      tx_busy_r       <= 1'b0;
      tx_pend_r       <= 1'b0;
      tx_shift_r      <= 9'h000;
      tx_idx_r        <= 4'h0;
      tx_data_r       <= 8'h00;
      tx_done_ev_r    <= 1'b0;
    end else begin
      tx_done_ev_r <= 1'b0;
      if (tx_bclk) begin
        if (tx_busy_r) begin
          if (tx_idx_r == UNB_TX_LAST) begin
            // Idle high doubles as the stop bit
            serial_tx_pin_r <= 1'b1; // [RULE23] [RULE1]
            tx_busy_r       <= 1'b0; // [RULE6]
            tx_done_ev_r    <= 1'b1;
          end else begin
            serial_tx_pin_r <= tx_shift_r[0]; // [RULE5]
            tx_shift_r      <= tx_shift_r >> 1;
            tx_idx_r        <= tx_idx_r + 4'h1;
          end
        end else if (tx_pend_r) begin
          serial_tx_pin_r <= 1'b0;
          tx_busy_r       <= 1'b1;
          tx_pend_r       <= 1'b0;
          tx_idx_r        <= 4'h0;
          tx_shift_r      <= {ctrl_r[UNB_CTRL_TB8], tx_data_r}; // [RULE5]
        end
      end
      if (buf_wr) begin
        tx_data_r <= wdata_r[7:0];
        tx_pend_r <= 1'b1; // [RULE4]
      end
    end
  end

  assign rx_maj  = unb_maj3(rx_smp_r);
  assign rx_hit  = !ctrl_r[UNB_CTRL_MPE] || rx_maj;
  assign rx_eval = rx_st_r == UNB_RX_BUSY && rx_tick && rx_cnt_r == UNB_EVAL;
  assign rx_ninth_eval = rx_eval && rx_idx_r == UNB_IDX_NINTH;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_st_r      <= UNB_RX_IDLE;
      rx_cnt_r     <= 4'h0;
      rx_idx_r     <= 4'h0;
      rx_smp_r     <= 3'h0;
      rx_shift_r   <= 8'h00;
      rx_buf_r     <= 8'h00;
      rx_ninth_bit_r <= 1'b0;
      rx_ok_r      <= 1'b0;
      rx_ovr_r     <= 1'b0;
      rx_done_ev_r <= 1'b0;
      rx_err_ev_r  <= 1'b0;
      rx_d_r       <= 1'b1;
      rx_prev_r    <= 1'b1;
    end else begin
      rx_d_r       <= serial_rx_pin;
      rx_prev_r    <= rx_d_r;
      rx_done_ev_r <= 1'b0;
      rx_err_ev_r  <= 1'b0;
      unique case (rx_st_r)
        UNB_RX_IDLE: begin
          if (rx_prev_r && !rx_d_r) begin // [RULE7]
            rx_st_r  <= UNB_RX_BUSY;
            rx_cnt_r <= 4'h0;
            rx_idx_r <= 4'h0;
            rx_ok_r  <= 1'b0;
            rx_ovr_r <= 1'b0;
          end
        end
        UNB_RX_BUSY: begin
          if (rx_tick) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r >= UNB_SMP_FIRST && rx_cnt_r <= UNB_SMP_LAST)
              rx_smp_r <= {rx_smp_r[1:0], rx_d_r}; // [RULE8] [RULE9]
            if (rx_cnt_r == UNB_CNT_LAST)
              rx_idx_r <= rx_idx_r + 4'h1;
          end
          if (rx_eval) begin
            if (rx_idx_r == 4'h0) begin
              if (rx_maj)
                rx_st_r <= UNB_RX_IDLE; // [RULE8]
            end else if (rx_idx_r < UNB_IDX_NINTH) begin
              // Shift register apart from buffer
              rx_shift_r <= {rx_maj, rx_shift_r[7:1]}; // [RULE9] [RULE12]
            end else if (rx_idx_r == UNB_IDX_NINTH) begin
              if (rx_hit && !rx_done_flag_r) begin // [RULE10] [RULE11]
                rx_buf_r       <= rx_shift_r;
                rx_ninth_bit_r <= rx_maj;
                rx_ok_r        <= 1'b1;
              end else if (rx_hit) begin
                rx_ovr_r <= 1'b1; // [RULE13]
              end
            end else begin
              // Errors only raise the flag
              rx_err_ev_r  <= !rx_maj || rx_ovr_r; // [RULE14] [RULE15]
              rx_done_ev_r <= rx_ok_r; // [RULE10]
              rx_st_r      <= UNB_RX_IDLE; // [RULE11] [RULE1]
            end
          end
        end
      endcase
    end
  end

  // Flags land on cycle1_state3; a set beats a same-cycle clear
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_done_pend_r      <= 1'b0;
      rx_done_pend_r      <= 1'b0;
      err_pend_r          <= 1'b0;
      tx_done_flag_r      <= 1'b0;
      rx_done_flag_r      <= 1'b0;
      serial_error_flag_r <= 1'b0;
    end else begin
      tx_done_pend_r <= tx_done_ev_r || (tx_done_pend_r && !m1s3_r);
      rx_done_pend_r <= rx_done_ev_r || (rx_done_pend_r && !m1s3_r);
      err_pend_r     <= rx_err_ev_r || (err_pend_r && !m1s3_r);
      tx_done_flag_r <= (m1s3_r && tx_done_pend_r) || // [RULE6]
        (tx_done_flag_r && !(stat_wr && wdata_r[UNB_STAT_TXD]));
      rx_done_flag_r <= (m1s3_r && rx_done_pend_r) ||
        (rx_done_flag_r && !(stat_wr && wdata_r[UNB_STAT_RXD]));
      serial_error_flag_r <= (m1s3_r && err_pend_r) || // [RULE14]
        (serial_error_flag_r && !(stat_wr && wdata_r[UNB_STAT_ERR]));
    end
  end

  a_tx_idle_high: assert property ( // [RULE23]
    @(posedge clk_sys) disable iff (reset)
    !tx_busy_r |-> serial_tx_pin_r)
    else $error("tx pin low while idle");

  a_tx_start_low: assert property ( // [RULE5]
    @(posedge clk_sys) disable iff (reset)
    $rose(tx_busy_r) |-> !serial_tx_pin_r ##1 !serial_tx_pin_r)
    else $error("start bit not low");

  // A doubler write mid-spacing legally moves the next tick
  a_fixed_rate_div: assert property ( // [RULE2]
    @(posedge clk_sys) disable iff (reset)
    (!ctrl_r[UNB_CTRL_DBL] && fix_tick) |=>
      (ctrl_r[UNB_CTRL_DBL] || !fix_tick) [*3] ##1
      (ctrl_r[UNB_CTRL_DBL] || fix_tick))
    else $error("fixed rate tick spacing wrong");

  a_tx_done_m1s3: assert property ( // [RULE6]
    @(posedge clk_sys) disable iff (reset)
    $rose(tx_done_flag_r) |-> $past(m1s3_r) && $past(tx_done_pend_r))
    else $error("tx done set off timing point");

  a_rx_start_reject: assert property ( // [RULE8]
    @(posedge clk_sys) disable iff (reset)
    (rx_eval && rx_idx_r == 4'h0 && rx_maj) |=> rx_st_r == UNB_RX_IDLE)
    else $error("false start not rejected");

  a_rx_buf_load: assert property ( // [RULE10]
    @(posedge clk_sys) disable iff (reset)
    (rx_ninth_eval && rx_hit && !rx_done_flag_r) |=>
      rx_buf_r == $past(rx_shift_r) && rx_ninth_bit_r == $past(rx_maj))
    else $error("receive buffer not loaded");

  a_overrun_keep: assert property ( // [RULE13]
    @(posedge clk_sys) disable iff (reset)
    (rx_ninth_eval && rx_hit && rx_done_flag_r) |=> $stable(rx_buf_r))
    else $error("overrun overwrote buffer");

  a_frame_error: assert property ( // [RULE14]
    @(posedge clk_sys) disable iff (reset)
    (rx_eval && rx_idx_r == UNB_IDX_STOP && !rx_maj) |->
      ##[1:14] serial_error_flag_r)
    else $error("framing error not flagged");

endmodule : unb_uart

// file: src/unb_pkg.sv
// Function
// [RULE1] Nine-bit frames are 11 bits: start, eight data, ninth bit, stop.
// [RULE2] Fixed-rate mode runs at osc/64, or osc/32 when doubled.
// [RULE3] Fixed-rate bit clock overflows a 16-state counter at osc/4 or osc/2.
// [RULE4] Writing serial_buffer starts a transmission with no other command.
// [RULE5] Transmit start, eight data bits LSB first, tx_ninth_bit, then stop.
// [RULE6] Transmit resets after ninth bit; tx_done_flag set at cycle1_state3.
// [RULE7] Falling edge on the receive pin starts the 16-state receive counter.
// [RULE8] Start bit sampled at 7, 8, 9; majority high resets receiver at 10.
// [RULE9] Each later bit is sampled at 7, 8, 9 and majority shifted in.
// [RULE10] Accepted ninth bit loads buffer and rx_ninth_bit; done after stop.
// [RULE11] Rejected frame leaves buffer, ninth bit, done flag; reset at stop.
// [RULE12] Input shift register is kept separate from the receive buffer.
// [RULE13] Overrun drops new data, keeps old buffer, sets error after stop.
// [RULE14] Low stop bit at state 10 sets error flag at next cycle1_state3.
// [RULE15] Overrun and framing errors only set the flag, nothing else changes.
// [RULE16] Remote transmitter bit period must equal one receive counter round.
// [RULE17] Variable-rate mode differs from fixed-rate only in bit-rate source.
// [RULE18] Transmit and receive select timer 1 or 2 overflow independently.
// [RULE19] Timer 1 overflow is divided by 32, or 16 when doubled.
// [RULE20] Timer 1 auto-reload runs at osc/12 over 256 minus reload value.
// [RULE21] Timer 2 overflow is divided by 16 regardless of baud_doubler.
// [RULE22] Timer 2 divides osc/2 or external input by 65536 minus reload.
// [RULE23] Transmit pin stays high while idle between frames.
package unb_pkg;

  localparam logic [7:0] UNB_OFS_CTRL  = 8'h00;
  localparam logic [7:0] UNB_OFS_STAT  = 8'h04;
  localparam logic [7:0] UNB_OFS_BUF   = 8'h08;
  localparam logic [7:0] UNB_OFS_T1RLD = 8'h0C;
  localparam logic [7:0] UNB_OFS_T2RLD = 8'h10;

  localparam int UNB_CTRL_VAR   = 0;
  localparam int UNB_CTRL_DBL   = 1;
  localparam int UNB_CTRL_MPE   = 2;
  localparam int UNB_CTRL_TXT2  = 3;
  localparam int UNB_CTRL_RXT2  = 4;
  localparam int UNB_CTRL_T2EXT = 5;
  localparam int UNB_CTRL_TB8   = 6;

  localparam int UNB_STAT_TXD  = 0;
  localparam int UNB_STAT_RXD  = 1;
  localparam int UNB_STAT_ERR  = 2;
  localparam int UNB_STAT_RB8  = 3;
  localparam int UNB_STAT_BUSY = 4;

  localparam logic [7:0]  UNB_CTRL_RST = 8'h00;
  localparam logic [7:0]  UNB_T1_RST   = 8'h00;
  localparam logic [15:0] UNB_T2_RST   = 16'h0000;

  localparam logic [3:0] UNB_MCYC_LAST  = 4'hB;
  localparam logic [3:0] UNB_M1S3_PHASE = 4'h2;
  localparam logic [3:0] UNB_CNT_LAST   = 4'hF;
  localparam logic [3:0] UNB_SMP_FIRST  = 4'h7;
  localparam logic [3:0] UNB_SMP_LAST   = 4'h9;
  localparam logic [3:0] UNB_EVAL       = 4'hA;
  localparam logic [3:0] UNB_IDX_NINTH  = 4'h9;
  localparam logic [3:0] UNB_IDX_STOP   = 4'hA;
  localparam logic [3:0] UNB_TX_LAST    = 4'h9;

  localparam logic [1:0] UNB_RESP_OKAY   = 2'h0;
  localparam logic [1:0] UNB_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    UNB_RX_IDLE = 2'b01,
    UNB_RX_BUSY = 2'b10
  } unb_rx_st_t;

endpackage : unb_pkg

// file: sim/unb_peer.sv
`timescale 1ns/10ps
module unb_peer (
  input  wire logic clk_sys,
  input  wire logic line_in,
  output logic      line_out
);
  int          bit_len;
  logic        seen;
  logic [10:0] got;

  initial begin
    line_out = 1'b1;
    bit_len  = 32;
    seen     = 1'b0;
    got      = '0;
  end

  task automatic send(input logic [7:0] d, input logic nb, input logic sp);
    logic [10:0] f;
    f = {sp, nb, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_sys);
      line_out <= f[i];
      repeat (bit_len - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    line_out <= 1'b1;
  endtask : send

  task automatic glitch(input int n);
    @(posedge clk_sys);
    line_out <= 1'b0;
    repeat (n) @(posedge clk_sys);
    line_out <= 1'b1;
  endtask : glitch

  // Mid-bit sampling; rearms mid stop bit, so a frame with no idle gap before it is still caught
  always begin
    @(negedge line_in);
    repeat (bit_len / 2) @(posedge clk_sys);
    for (int i = 0; i < 11; i++) begin
      got[i] = line_in;
      if (i < 10) repeat (bit_len) @(posedge clk_sys);
    end
    seen = 1'b1;
  end
endmodule : unb_peer

// file: sim/tb.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin \
  comparisons++; \
  if ((s) !== (e)) begin \
    miscompares++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, s); \
  end \
end
module tb;
  import unb_pkg::*;
  logic        clk_sys, reset;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        tx_pin, rx_pin;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  int          miscompares, comparisons;

  unb_uart DUT (
    .clk_sys          (clk_sys),
    .reset            (reset),
    .s_axi_awaddr     (awaddr),
    .s_axi_awvalid    (awvalid),
    .s_axi_awready    (awready),
    .s_axi_wdata      (wdata),
    .s_axi_wstrb      (4'hF),
    .s_axi_wvalid     (wvalid),
    .s_axi_wready     (wready),
    .s_axi_bresp      (bresp),
    .s_axi_bvalid     (bvalid),
    .s_axi_bready     (bready),
    .s_axi_araddr     (araddr),
    .s_axi_arvalid    (arvalid),
    .s_axi_arready    (arready),
    .s_axi_rdata      (rdata),
    .s_axi_rresp      (rresp),
    .s_axi_rvalid     (rvalid),
    .s_axi_rready     (rready),
    .timer2_ext_input (1'b0),
    .serial_rx_pin    (rx_pin),
    .serial_tx_pin    (tx_pin)
  );

  unb_peer peer (
    .clk_sys  (clk_sys),
    .line_in  (tx_pin),
    .line_out (rx_pin)
  );

  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    v  = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic expect_reg(input string n, input logic [7:0] a,
                            input logic [31:0] e);
    rd(a, d, r);
    `CHK(n, e, d)
    `CHK("rd resp", UNB_RESP_OKAY, r)
  endtask : expect_reg

  task automatic t_reset;
    `CHK("tx idle", 1'b1, tx_pin)
    expect_reg("ctrl", UNB_OFS_CTRL, 32'h0);
    expect_reg("status", UNB_OFS_STAT, 32'h0);
    rd(8'h14, d, r);
    `CHK("rd resp", UNB_RESP_SLVERR, r)
    wr(8'h14, 32'h1, r);
    `CHK("wr resp", UNB_RESP_SLVERR, r)
  endtask : t_reset

  task automatic t_tx(input logic [7:0] ctl, input logic [7:0] v,
                      input int bl);
    wr(UNB_OFS_CTRL, {24'h0, ctl}, r);
    peer.bit_len = bl;
    peer.seen    = 1'b0;
    wr(UNB_OFS_BUF, {24'h0, v}, r);
    `CHK("wr resp", UNB_RESP_OKAY, r)
    // Timer 1 may need a full slow round before its first reload
    for (int i = 0; i < 6000 && peer.seen !== 1'b1; i++)
      @(posedge clk_sys);
    `CHK("seen", 1'b1, peer.seen)
    `CHK("frame", {1'b1, ctl[6], v, 1'b0}, peer.got)
    repeat (bl) @(posedge clk_sys);
    `CHK("tx idle", 1'b1, tx_pin)
    expect_reg("tx done", UNB_OFS_STAT, 32'h1);
    wr(UNB_OFS_STAT, 32'h7, r);
  endtask : t_tx

  task automatic t_rx(input logic [7:0] v, input logic nb, input logic sp,
                      input logic [31:0] st, input logic [31:0] bv);
    peer.send(v, nb, sp);
    repeat (40) @(posedge clk_sys);
    expect_reg("status", UNB_OFS_STAT, st);
    expect_reg("rx buf", UNB_OFS_BUF, bv);
  endtask : t_rx

  task automatic t_glitch;
    peer.glitch(6);
    repeat (400) @(posedge clk_sys);
    expect_reg("false start", UNB_OFS_STAT, 32'h0);
  endtask : t_glitch

  task automatic t_reload;
    wr(UNB_OFS_T1RLD, 32'hFF, r);
    expect_reg("t1 reload", UNB_OFS_T1RLD, 32'hFF);
    wr(UNB_OFS_T2RLD, 32'hFFFE, r);
    expect_reg("t2 reload", UNB_OFS_T2RLD, 32'hFFFE);
  endtask : t_reload

  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Whole run is under 15000 cycles; the limit leaves wide margin
  initial begin
    #200000;
    miscompares++;
    report_and_stop;
  end

  initial begin
    reset   = 1'b1;
    awaddr  = '0;
    araddr  = '0;
    wdata   = '0;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    miscompares = 0;
    comparisons = 0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset;
    t_tx(8'h00, 8'hA5, 64);
    t_tx(8'h42, 8'h3C, 32);
    t_rx(8'h3C, 1'b1, 1'b1, 32'h0A, 32'h3C);
    t_rx(8'h55, 1'b0, 1'b1, 32'h0E, 32'h3C);
    wr(UNB_OFS_STAT, 32'h7, r);
    wr(UNB_OFS_CTRL, 32'h06, r);
    t_rx(8'h77, 1'b0, 1'b1, 32'h08, 32'h3C);
    t_rx(8'h81, 1'b1, 1'b1, 32'h0A, 32'h81);
    wr(UNB_OFS_STAT, 32'h7, r);
    wr(UNB_OFS_CTRL, 32'h02, r);
    t_rx(8'h66, 1'b0, 1'b0, 32'h06, 32'h66);
    wr(UNB_OFS_STAT, 32'h7, r);
    t_glitch;
    t_reload;
    t_tx(8'h03, 8'h5A, 192);
    t_rx(8'hC3, 1'b1, 1'b1, 32'h0A, 32'hC3);
    report_and_stop;
  end
endmodule : tb
